// [dmpc_bridge_model.sv]
/*
 Far side of the motor pins: inverting couplers feeding an H-bridge driver.
 Assumes the four direction pins of the block and nothing else.
*/
`timescale 1ns/1ps

module dmpc_bridge_model (
	input  wire logic right_drive_pos,
	input  wire logic right_drive_neg,
	input  wire logic left_drive_pos,
	input  wire logic left_drive_neg,
	output logic      right_in1,
	output logic      right_in2,
	output logic      left_in1,
	output logic      left_in2
);
	// couplers invert every pin before the driver inputs
	assign right_in1 = ~right_drive_pos;
	assign right_in2 = ~right_drive_neg;
	assign left_in1  = ~left_drive_pos;
	assign left_in2  = ~left_drive_neg;
endmodule // dmpc_bridge_model

// [dmpc_channel.sv]
/*
 One motor channel: period counter, raw pwm wave and direction decode.
 Assumes period, on-length registers and next control value from the
 register file on the same clock.
*/
`timescale 1ns/1ps
`include "dmpc_defines.svh"

module dmpc_channel
	import dmpc_pkg::*;
#(
	parameter int CNT_W = 32
)(
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic [CNT_W-1:0]  period,
	input  wire logic [CNT_W-1:0]  on_len,
	input  wire dmpc_ctrl_t        ctrl_next,
	output dmpc_drive_t            drive,
	output logic                   wave
);

	if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
		$error("dmpc_channel: CNT_W must lie in 2..32");
	end

	logic [CNT_W-1:0] tick;
	logic [CNT_W-1:0] next_tick;
	logic             next_wave;
	dmpc_drive_t      next_drive;

	// counter wrap and wave compare
	always_comb begin
		if (tick >= period) begin
			next_tick = CNT_W'(`DMPC_TICK_RST);
		end else begin
			next_tick = tick + CNT_W'(1);
		end
		next_wave = (tick <= on_len);
	end

	// period counter
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tick <= CNT_W'(`DMPC_TICK_RST);
		end else begin
			tick <= next_tick;
		end
	end

	// raw wave, no reset
	always_ff @(posedge clk) begin
		wave <= next_wave;
	end

	// decode from next values so pins move on the same edge as their cause
	always_comb begin
		if (ctrl_next.go) begin
			next_drive.dir_b = ctrl_next.forward;
			next_drive.dir_a = !ctrl_next.forward;
			next_drive.speed = next_wave;
		end else if (ctrl_next.fast) begin
			next_drive = '{dir_b: 1'b1, dir_a: 1'b1, speed: 1'b0};
		end else begin
			next_drive = '{dir_b: 1'b0, dir_a: 1'b0, speed: 1'b0};
		end
	end

	// pin register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			drive <= '0;
		end else begin
			drive <= next_drive;
		end
	end

	// forward run drives b high, a low, wave through
	chk_fwd_drive: assert property (@(posedge clk) disable iff (!reset_n)
		ctrl_next.go && ctrl_next.forward |=> drive.dir_b && !drive.dir_a
			&& drive.speed == wave)
		else $error("forward drive pattern wrong");

	// backward run drives a high, b low, wave through
	chk_back_drive: assert property (@(posedge clk) disable iff (!reset_n)
		ctrl_next.go && !ctrl_next.forward |=> !drive.dir_b && drive.dir_a
			&& drive.speed == wave)
		else $error("backward drive pattern wrong");

	// fast brake holds both high, speed low
	chk_fast_brake: assert property (@(posedge clk) disable iff (!reset_n)
		!ctrl_next.go && ctrl_next.fast |=> drive == 3'b110)
		else $error("fast brake pattern wrong");

	// short brake holds all low
	chk_short_brake: assert property (@(posedge clk) disable iff (!reset_n)
		!ctrl_next.go && !ctrl_next.fast |=> drive == 3'b000)
		else $error("short brake pattern wrong");

	// counter reloads to one at or past the period
	chk_tick_wrap: assert property (@(posedge clk) disable iff (!reset_n)
		tick >= period |=> tick == CNT_W'(1))
		else $error("counter failed to reload");

	// counter steps by one below the period; the release edge itself still resets
	chk_tick_step: assert property (@(posedge clk) disable iff (!reset_n)
		reset_n && tick < period |=> tick == $past(tick) + CNT_W'(1))
		else $error("counter failed to step");

	// wave follows the on-length compare one edge later
	chk_wave_cmp: assert property (@(posedge clk) disable iff (!reset_n)
		1'b1 |=> wave == ($past(tick) <= $past(on_len)))
		else $error("raw wave compare wrong");

endmodule // dmpc_channel

// [dmpc_defines.svh]
/*
 Register offsets, field positions, reset values and counts for the motor
 pwm and direction block. Assumes inclusion by bare name from design files.
*/
`ifndef DMPC_DEFINES_SVH
`define DMPC_DEFINES_SVH

// register word indices within one motor window (byte address = 4 * index)
`define DMPC_IDX_PERIOD 2'h0
`define DMPC_IDX_ON_LEN 2'h1
`define DMPC_IDX_CTRL   2'h2
`define DMPC_IDX_STATUS 2'h3

// motor window select: address bit 4, right motor at 8'h00, left at 8'h10
`define DMPC_MOTOR_BIT  4
`define DMPC_ADDR_W     8

// control word field positions
`define DMPC_CTRL_GO    0
`define DMPC_CTRL_FWD   1
`define DMPC_CTRL_FAST  2

// reset values
`define DMPC_PERIOD_RST 32'h00001B58
`define DMPC_ON_LEN_RST 32'h00000000
`define DMPC_CTRL_RST   3'h0
`define DMPC_TICK_RST   1

// bus answers
`define DMPC_RESP_OKAY   2'h0
`define DMPC_RESP_SLVERR 2'h2

`endif

// [dmpc_pkg.sv]
/*
 Types shared by the motor pwm and direction block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package dmpc_pkg;

	// software control bits of one motor
	typedef struct packed {
		logic fast;
		logic forward;
		logic go;
	} dmpc_ctrl_t;

	// pins of one motor driver channel
	typedef struct packed {
		logic dir_b;
		logic dir_a;
		logic speed;
	} dmpc_drive_t;

endpackage

// [dmpc_top.sv]
/*
 Motor pwm and direction block: AXI4-Lite register file for two motors and
 two pwm channels whose pins reach an H-bridge driver through inverting
 couplers. Assumes one 50 MHz clock and an AXI4-Lite master on that clock.
*/
// How it works
// - run and forward: b high, a low, pwm wave passed through.
// - run and backward: b low, a high, pwm wave passed through.
// - fast braking and stopped: both direction pins high, pwm low.
// - short braking and stopped: both direction pins low, pwm low.
// - two identical channels; left direction pins wired swapped against right.
// - 32-bit period counter loads one asynchronously under reset.
// - counter reloads to one at or above period, else increments.
// - raw wave registered high while counter not above on-length; no reset.
// - period at word 0, on-length at word 1, both read-write.
// - control word at word 2: bit2 fast, bit1 forward, bit0 run.
`timescale 1ns/1ps
`include "dmpc_defines.svh"

module dmpc_top
	import dmpc_pkg::*;
#(
	parameter int CNT_W = 32
)(
	input  wire logic                    clk,
	input  wire logic                    reset_n,
	input  wire logic [`DMPC_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [`DMPC_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	output logic                         right_drive_pos,
	output logic                         right_drive_neg,
	output logic                         right_speed_out,
	output logic                         left_drive_pos,
	output logic                         left_drive_neg,
	output logic                         left_speed_out
);

	if (CNT_W != 32) begin : g_bad_width
		$error("dmpc_top: register words hold a 32-bit counter only");
	end

	// byte-wise merge of a write into an old word
	function automatic logic [31:0] merge(input logic [31:0] old_word,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old_word;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = data[8*b +: 8];
			end
		end
		return res;
	endfunction

	// address is mapped when upper bits clear; for a write the status word is not mapped
	function automatic logic mapped(input logic [`DMPC_ADDR_W-1:0] a,
		input logic for_write);
		logic ok;
		ok = (a[`DMPC_ADDR_W-1:`DMPC_MOTOR_BIT+1] == '0);
		if (for_write && a[3:2] == `DMPC_IDX_STATUS) begin
			ok = 1'b0;
		end
		return ok;
	endfunction

	// register file
	logic [31:0]      period [2];
	logic [31:0]      on_len [2];
	dmpc_ctrl_t       ctrl [2];
	logic [31:0]      next_period [2];
	logic [31:0]      next_on_len [2];
	dmpc_ctrl_t       next_ctrl [2];
	logic [1:0]       wave;
	dmpc_drive_t      drive [2];

	// write channel state
	logic                    aw_held;
	logic [`DMPC_ADDR_W-1:0] aw_addr_q;
	logic                    w_held;
	logic [31:0]             w_data_q;
	logic [3:0]              w_strb_q;
	logic                    next_aw_held;
	logic [`DMPC_ADDR_W-1:0] next_aw_addr_q;
	logic                    next_w_held;
	logic [31:0]             next_w_data_q;
	logic [3:0]              next_w_strb_q;
	logic                    next_awready;
	logic                    next_wready;
	logic                    next_bvalid;
	logic [1:0]              next_bresp;
	logic                    do_write;
	logic                    wr_ok;
	logic                    wr_m;

	// read channel state
	logic                    next_arready;
	logic                    next_rvalid;
	logic [31:0]             next_rdata;
	logic [1:0]              next_rresp;
	logic                    rd_m;

	// write path: take address and data in either order, then commit
	always_comb begin
		next_aw_held   = aw_held;
		next_aw_addr_q = aw_addr_q;
		next_w_held    = w_held;
		next_w_data_q  = w_data_q;
		next_w_strb_q  = w_strb_q;
		next_bvalid    = s_axi_bvalid;
		next_bresp     = s_axi_bresp;
		next_period    = period;
		next_on_len    = on_len;
		next_ctrl      = ctrl;
		do_write       = aw_held && w_held && !s_axi_bvalid;
		wr_ok          = mapped(aw_addr_q, 1'b1);
		wr_m           = aw_addr_q[`DMPC_MOTOR_BIT];
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held   = 1'b1;
			next_aw_addr_q = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held   = 1'b1;
			next_w_data_q = s_axi_wdata;
			next_w_strb_q = s_axi_wstrb;
		end
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = wr_ok ? `DMPC_RESP_OKAY : `DMPC_RESP_SLVERR;
			if (wr_ok) begin
				unique case (aw_addr_q[3:2])
					`DMPC_IDX_PERIOD: begin
						next_period[wr_m] = merge(period[wr_m], w_data_q, w_strb_q);
					end
					`DMPC_IDX_ON_LEN: begin
						next_on_len[wr_m] = merge(on_len[wr_m], w_data_q, w_strb_q);
					end
					`DMPC_IDX_CTRL: begin
						if (w_strb_q[0]) begin
							next_ctrl[wr_m].go      = w_data_q[`DMPC_CTRL_GO];
							next_ctrl[wr_m].forward = w_data_q[`DMPC_CTRL_FWD];
							next_ctrl[wr_m].fast    = w_data_q[`DMPC_CTRL_FAST];
						end
					end
					default: begin
					end
				endcase
			end
		end
		next_awready = !next_aw_held && !next_bvalid;
		next_wready  = !next_w_held && !next_bvalid;
	end

	// write path registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_held       <= 1'b0;
			aw_addr_q     <= '0;
			w_held        <= 1'b0;
			w_data_q      <= '0;
			w_strb_q      <= '0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `DMPC_RESP_OKAY;
			for (int m = 0; m < 2; m++) begin
				period[m] <= `DMPC_PERIOD_RST;
				on_len[m] <= `DMPC_ON_LEN_RST;
				ctrl[m]   <= `DMPC_CTRL_RST;
			end
		end else begin
			aw_held       <= next_aw_held;
			aw_addr_q     <= next_aw_addr_q;
			w_held        <= next_w_held;
			w_data_q      <= next_w_data_q;
			w_strb_q      <= next_w_strb_q;
			s_axi_awready <= next_awready;
			s_axi_wready  <= next_wready;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			period        <= next_period;
			on_len        <= next_on_len;
			ctrl          <= next_ctrl;
		end
	end

	// read path: one read at a time, data one edge after address
	always_comb begin
		next_rvalid = s_axi_rvalid;
		next_rdata  = s_axi_rdata;
		next_rresp  = s_axi_rresp;
		rd_m        = s_axi_araddr[`DMPC_MOTOR_BIT];
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp  = `DMPC_RESP_OKAY;
			next_rdata  = '0;
			if (!mapped(s_axi_araddr, 1'b0)) begin
				next_rresp = `DMPC_RESP_SLVERR;
			end else begin
				unique case (s_axi_araddr[3:2])
					`DMPC_IDX_PERIOD: next_rdata = period[rd_m];
					`DMPC_IDX_ON_LEN: next_rdata = on_len[rd_m];
					`DMPC_IDX_CTRL:   next_rdata = {29'h0, ctrl[rd_m]};
					`DMPC_IDX_STATUS: next_rdata = {31'h0, wave[rd_m]};
				endcase
			end
		end
		next_arready = !next_rvalid;
	end

	// read path registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= `DMPC_RESP_OKAY;
		end else begin
			s_axi_arready <= next_arready;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
		end
	end

	// two identical channels, index 0 right, index 1 left
	for (genvar m = 0; m < 2; m++) begin : g_motor
		dmpc_channel #(
			.CNT_W     (CNT_W)
		) u_channel (
			.clk       (clk),
			.reset_n   (reset_n),
			.period    (period[m]),
			.on_len    (on_len[m]),
			.ctrl_next (next_ctrl[m]),
			.drive     (drive[m]),
			.wave      (wave[m])
		);
	end

	// left motor faces the other way, so its direction pins are swapped
	assign right_drive_pos = drive[0].dir_a;
	assign right_drive_neg = drive[0].dir_b;
	assign right_speed_out = drive[0].speed;
	assign left_drive_neg  = drive[1].dir_a;
	assign left_drive_pos  = drive[1].dir_b;
	assign left_speed_out  = drive[1].speed;

	// full period write lands one edge after commit
	chk_period_write: assert property (@(posedge clk) disable iff (!reset_n)
		do_write && wr_ok && aw_addr_q[3:2] == `DMPC_IDX_PERIOD && w_strb_q == 4'hF
			|=> period[$past(wr_m)] == $past(w_data_q))
		else $error("period write not stored");

	// full on-length write lands one edge after commit
	chk_on_len_write: assert property (@(posedge clk) disable iff (!reset_n)
		do_write && wr_ok && aw_addr_q[3:2] == `DMPC_IDX_ON_LEN && w_strb_q == 4'hF
			|=> on_len[$past(wr_m)] == $past(w_data_q))
		else $error("on-length write not stored");

	// writes to the status word are refused
	chk_status_ro: assert property (@(posedge clk) disable iff (!reset_n)
		do_write && aw_addr_q[3:2] == `DMPC_IDX_STATUS
			|=> s_axi_bvalid && s_axi_bresp == `DMPC_RESP_SLVERR)
		else $error("status write not refused");

	// fast brake written to right motor shows on its pins at once
	chk_ctrl_pins: assert property (@(posedge clk) disable iff (!reset_n)
		do_write && wr_ok && aw_addr_q == {4'h0, `DMPC_IDX_CTRL, 2'h0} && w_strb_q[0]
			&& w_data_q[2:0] == 3'b100
			|=> right_drive_pos && right_drive_neg && !right_speed_out)
		else $error("control write did not reach pins");

	// control word reads back in the low three bits
	chk_ctrl_read: assert property (@(posedge clk) disable iff (!reset_n)
		s_axi_arvalid && s_axi_arready && s_axi_araddr == {4'h0, `DMPC_IDX_CTRL, 2'h0}
			|=> s_axi_rvalid && s_axi_rdata == {29'h0, $past(ctrl[0])})
		else $error("control word read back wrong");

	// unmapped read answers slave error
	chk_unmapped_rd: assert property (@(posedge clk) disable iff (!reset_n)
		s_axi_arvalid && s_axi_arready && s_axi_araddr[7:5] != 3'h0
			|=> s_axi_rvalid && s_axi_rresp == `DMPC_RESP_SLVERR)
		else $error("unmapped read not refused");

endmodule // dmpc_top

// [dmpc_top_test.sv]
/*
 Self-checking bench for the motor pwm and direction block.
 Assumes the block's AXI4-Lite slave on one 50 MHz clock.
*/
`timescale 1ns/1ps
`include "dmpc_defines.svh"

module dmpc_top_test import dmpc_pkg::*;;
	logic        clk, reset_n, rst_q;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        r_pos, r_neg, r_spd, l_pos, l_neg, l_spd;
	logic        r_in1, r_in2, l_in1, l_in2;
	logic [2:0]  er, el;
	logic [2:0]  m_ctl[2];
	int unsigned m_per[2], m_on[2], tk[2];
	bit          wv[2];
	bit          busy, chk_en;
	int          n_errors, n_compared, seed, per, on;

	dmpc_top #(.CNT_W(32)) dmpc_top_inst (.clk(clk), .reset_n(reset_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .right_drive_pos(r_pos), .right_drive_neg(r_neg),
		.right_speed_out(r_spd), .left_drive_pos(l_pos), .left_drive_neg(l_neg),
		.left_speed_out(l_spd));

	dmpc_bridge_model dmpc_bridge_model_inst (.right_drive_pos(r_pos),
		.right_drive_neg(r_neg), .left_drive_pos(l_pos), .left_drive_neg(l_neg),
		.right_in1(r_in1), .right_in2(r_in2), .left_in1(l_in1), .left_in2(l_in2));

	// free running 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// reset level as seen by the last rising edge
	always @(posedge clk) rst_q <= reset_n;

	// expected {dir_a, dir_b, speed} for a control word and raw wave
	function automatic logic [2:0] exp_pins(input logic [2:0] c, input bit w);
		if (c[0])
			return c[1] ? {2'b01, w} : {2'b10, w};
		return c[2] ? 3'b110 : 3'b000;
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// counter and wave model, pins compared after every edge settles while no write is in flight
	always @(negedge clk) begin
		for (int i = 0; i < 2; i++) begin
			if (!rst_q) begin
				wv[i] = (1 <= m_on[i]);
				tk[i] = 1;
			end else begin
				wv[i] = (tk[i] <= m_on[i]);
				tk[i] = (tk[i] >= m_per[i]) ? 1 : tk[i] + 1;
			end
		end
		er = exp_pins(m_ctl[0], wv[0]);
		el = exp_pins(m_ctl[1], wv[1]);
		if (chk_en && !busy)
			check("motor pins", {26'h0, r_pos, r_neg, r_spd, l_pos, l_neg, l_spd},
				{26'h0, er, el[1], el[2], el[0]});
	end

	// one write; model follows once the response is taken
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er_);
		int t;
		bit aw_done, w_done, b_done;
		@(posedge clk);
		busy = 1;
		aw_done = 0;
		w_done = 0;
		b_done = 0;
		t = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b_done) begin
			@(posedge clk);
			t++;
			if (!aw_done && s_axi_awready) begin
				aw_done = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready) begin
				w_done = 1;
				s_axi_wvalid <= 1'b0;
			end
			if (s_axi_bvalid) begin
				check("write response", {30'h0, s_axi_bresp}, {30'h0, er_});
				s_axi_bready <= 1'b0;
				b_done = 1;
			end else if (t >= 100) begin
				check("write timeout", 32'h1, 32'h0);
				wrap_up();
			end
		end
		if (er_ == `DMPC_RESP_OKAY) begin
			case (a[3:2])
				2'h0: m_per[a[4]] = d;
				2'h1: m_on[a[4]] = d;
				default: m_ctl[a[4]] = d[2:0];
			endcase
		end
		busy = 0;
	endtask

	// one read, data and response compared
	task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er_);
		int t;
		bit ar_done, r_done;
		@(posedge clk);
		ar_done = 0;
		r_done = 0;
		t = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!r_done) begin
			@(posedge clk);
			t++;
			if (!ar_done && s_axi_arready) begin
				ar_done = 1;
				s_axi_arvalid <= 1'b0;
			end
			if (s_axi_rvalid) begin
				check("read data", s_axi_rdata, ed);
				check("read response", {30'h0, s_axi_rresp}, {30'h0, er_});
				s_axi_rready <= 1'b0;
				r_done = 1;
			end else if (t >= 100) begin
				check("read timeout", 32'h1, 32'h0);
				wrap_up();
			end
		end
	endtask

	// watchdog sized well above the expected run
	initial begin
		repeat (40000) @(posedge clk);
		n_errors++;
		wrap_up();
	end

	// main sequence
	initial begin
		seed = 73920;
		reset_n = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		for (int i = 0; i < 2; i++) begin
			m_per[i] = 7000;
			m_on[i] = 0;
			m_ctl[i] = 3'h0;
		end
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		chk_en = 1;
		axi_read(8'h00, 32'h00001B58, `DMPC_RESP_OKAY);
		axi_read(8'h18, 32'h00000000, `DMPC_RESP_OKAY);
		axi_write(8'h20, 32'h00000005, `DMPC_RESP_SLVERR);
		axi_read(8'h24, 32'h00000000, `DMPC_RESP_SLVERR);
		// status word: wave stays low with on-length zero, and it refuses writes
		axi_read(8'h0C, 32'h00000000, `DMPC_RESP_OKAY);
		axi_write(8'h1C, 32'h00000001, `DMPC_RESP_SLVERR);
		$display("test register map done");
		// every control mode on each motor with random period and on-length
		for (int m = 0; m < 2; m++) begin
			for (int c = 0; c < 8; c++) begin
				per = ($random(seed) & 31) + 1;
				on = $random(seed) & 63;
				axi_write(8'(m * 16), 32'(per), `DMPC_RESP_OKAY);
				axi_write(8'(m * 16 + 4), 32'(on), `DMPC_RESP_OKAY);
				axi_write(8'(m * 16 + 8), 32'(c), `DMPC_RESP_OKAY);
				repeat (3 * per + 4) @(posedge clk);
				axi_read(8'(m * 16), 32'(per), `DMPC_RESP_OKAY);
				axi_read(8'(m * 16 + 4), 32'(on), `DMPC_RESP_OKAY);
				axi_read(8'(m * 16 + 8), 32'(c), `DMPC_RESP_OKAY);
				$display("test motor %0d mode %0d done", m, c);
			end
		end
		// software default period on both motors, one full pwm cycle watched
		axi_write(8'h00, 32'h00001B58, `DMPC_RESP_OKAY);
		axi_write(8'h10, 32'h00001B58, `DMPC_RESP_OKAY);
		repeat (7004) @(posedge clk);
		$display("test default period done");
		// both running forward: motors mounted opposite turn opposite ways
		check("right driver inputs", {30'h0, r_in1, r_in2}, 32'h2);
		check("left driver inputs", {30'h0, l_in1, l_in2}, 32'h1);
		$display("test mounting done");
		wrap_up();
	end
endmodule // dmpc_top_test
